// file: hw/pin_conditioner.sv
`timescale 1ns/1ps
// Brings asynchronous active-low panel pins into the clock domain and
// gives both the settled level and a one-cycle press pulse.
module pin_conditioner #(
    parameter int WIDTH = 5
) (
    input wire logic hclk, // System clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] pin_n, // Raw pins, low while tied to common.
    output logic [WIDTH-1:0] level, // Synchronised level, high when active.
    output logic [WIDTH-1:0] press // One-cycle pulse on activation.
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    generate
        if (WIDTH < 1)
        begin : g_bad
            $error("pin_conditioner needs at least one pin");
        end
    endgenerate

    // Two flops before any logic; the first is read by the second only.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= ~pin_n;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign press = sync_q & ~prev_q;
endmodule

// file: hw/setpoint_relay_color_logic.sv
`timescale 1ns/1ps
`include "meter_map.svh"
// Function
// R1 - High mode energizes above the setpoint
// R2 - Low mode energizes below the setpoint
// R3 - Four activation digits, setpoint one leftmost
// R4 - Program press advances digit, flashing with point
// R5 - Only setpoint one has delay timers
// R6 - Each setpoint has its own hysteresis enable
// R7 - After fourth digit exit or colour menu
// R8 - Whole bar shows one zone colour
// R9 - Base colour below the lowest setpoint
// R10 - Colour above setpoint follows value, not number
// R11 - Equal setpoints: highest number colour wins
// R12 - Colours are green, orange or red only
// R13 - Colour menu base then four, then exit
// R14 - Horizontal bar: below left, above right
// R15 - Relays driven in order three, one, four, two
// R16 - Lock allows viewing but rejects changes
// R17 - Dim halves the selected brightness
// R18 - Pump mode bands setpoint one between one and two
// R19 - Make delay needs continuous alarm condition
// R20 - Re-evaluate on every new conversion result
module setpoint_relay_color_logic
    import meter_pkg::*;
#(
    parameter int CYCLES_PER_SECOND = `CLK_HZ * `DELAY_UNIT_S,
    parameter int BLINK_CYCLES = (`CLK_HZ / 1000) * `BLINK_MS
) (
    input wire logic hclk, // System clock, 25 MHz.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // AHB-Lite slave select.
    input wire logic [31:0] haddr, // AHB-Lite address.
    input wire logic [1:0] htrans, // AHB-Lite transfer type.
    input wire logic hwrite, // AHB-Lite write flag.
    input wire logic [2:0] hsize, // AHB-Lite size, word only.
    input wire logic [31:0] hwdata, // AHB-Lite write data.
    input wire logic hready, // AHB-Lite bus ready.
    output logic hreadyout, // Always ready, no wait states.
    output logic hresp, // Always OKAY.
    output logic [31:0] hrdata, // Registered read data.
    input wire meter_pkg::reading_s reading, // Conversion result stream.
    input wire logic btn_prog_n, // Program button pin.
    input wire logic btn_up_n, // Up button pin.
    input wire logic btn_down_n, // Down button pin.
    input wire logic lock_n, // Lock pin, low when tied to common.
    input wire logic dim_n, // Dim pin, low when tied to common.
    output logic [3:0] relay_drive, // Relay coils, one per rear relay.
    output meter_pkg::bar_s bar, // Bargraph colour and brightness.
    output meter_pkg::edit_s edit // Menu state for the digit display.
);
    logic [4:0] pin_level;
    logic [4:0] pin_press;
    logic locked;
    logic dimmed;
    logic wr_q;
    logic [7:0] wa_q;
    logic wr_en;
    logic [5:0] ctrl_q;
    logic [3:0] act_q;
    logic [3:0] hys_q;
    logic [15:0] band_q;
    logic signed [15:0] sp_q [4];
    logic [13:0] make_q;
    logic [13:0] break_q;
    colour_e col_q [5];
    logic [3:0] alarm_q;
    logic relay_one_q;
    logic [13:0] dly_cnt_q;
    logic [31:0] sec_cnt_q;
    logic sec_tick;
    colour_e colour_q;
    colour_e zone_colour;
    menu_e menu_q;
    logic [2:0] step_q;
    logic [31:0] blink_cnt_q;
    logic blank_q;
    logic pump_act;

    generate
        if (CYCLES_PER_SECOND < 1 || BLINK_CYCLES < 1)
        begin : g_bad
            $error("timing counts must be at least one cycle");
        end
    endgenerate

    // Widens a 16-bit value so sums and differences cannot wrap.
    function automatic logic signed [17:0] wide(input logic signed [15:0] v);
        return {{2{v[15]}}, v};
    endfunction

    // Keeps the stored colour when software writes the unused code.
    function automatic colour_e pick_colour(input logic [1:0] v, input colour_e old);
        return (v == 2'b11) ? old : colour_e'(v);
    endfunction

    // Steps through the three colours in either direction.
    function automatic colour_e step_colour(input colour_e c, input logic up);
        unique case (c)
            COLOUR_GREEN: return up ? COLOUR_ORANGE : COLOUR_RED;
            COLOUR_ORANGE: return up ? COLOUR_RED : COLOUR_GREEN;
            default: return up ? COLOUR_GREEN : COLOUR_ORANGE;
        endcase
    endfunction

    // Bits: 0 program, 1 up, 2 down, 3 lock, 4 dim.
    pin_conditioner #(.WIDTH(5)) u_pins (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_n({dim_n, lock_n, btn_down_n, btn_up_n, btn_prog_n}),
        .level(pin_level),
        .press(pin_press)
    );
    assign locked = pin_level[3];
    assign dimmed = pin_level[4];

    // The slave never stalls and never errors.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture; reads are answered from flops in the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_q <= 1'b0;
            if (hsel && htrans[1] && hready)
            begin
                wr_q <= hwrite;
                wa_q <= haddr[7:0];
                if (!hwrite)
                begin
                    unique case (haddr[7:0])
                        `OFS_CTRL: hrdata <= {26'h0, ctrl_q};
                        `OFS_MODE: hrdata <= {24'h0, hys_q, act_q};
                        `OFS_HBAND: hrdata <= {16'h0, band_q};
                        `OFS_SP1: hrdata <= {16'h0, sp_q[0]};
                        `OFS_SP2: hrdata <= {16'h0, sp_q[1]};
                        `OFS_SP3: hrdata <= {16'h0, sp_q[2]};
                        `OFS_SP4: hrdata <= {16'h0, sp_q[3]};
                        `OFS_MAKE: hrdata <= {18'h0, make_q};
                        `OFS_BREAK: hrdata <= {18'h0, break_q};
                        `OFS_COLOUR: hrdata <= {22'h0, col_q[4], col_q[3], col_q[2],
                            col_q[1], col_q[0]};
                        `OFS_STATUS: hrdata <= {14'h0, dimmed, locked, 1'b0, menu_q,
                            2'b00, colour_q, alarm_q, relay_drive};
                        default: hrdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // R16 lock blocks writes
    assign wr_en = wr_q && !locked;

    // Plain parameters written only over the bus.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= `RST_CTRL;
            band_q <= `RST_HBAND;
            for (int i = 0; i < 4; i++)
            begin
                sp_q[i] <= `RST_SP;
            end
            make_q <= `RST_DELAY;
            break_q <= `RST_DELAY;
        end
        else if (wr_en)
        begin
            unique case (wa_q)
                `OFS_CTRL: ctrl_q <= hwdata[5:0];
                `OFS_HBAND: band_q <= hwdata[15:0];
                `OFS_SP1: sp_q[0] <= hwdata[15:0];
                `OFS_SP2: sp_q[1] <= hwdata[15:0];
                `OFS_SP3: sp_q[2] <= hwdata[15:0];
                `OFS_SP4: sp_q[3] <= hwdata[15:0];
                `OFS_MAKE: make_q <= (hwdata[15:0] > 16'd9999) ? `DELAY_MAX : hwdata[13:0];
                `OFS_BREAK: break_q <= (hwdata[15:0] > 16'd9999) ? `DELAY_MAX : hwdata[13:0];
                default: ;
            endcase
        end
    end

    // Activation digits, written by bus or menu, and hysteresis enables, written by bus only.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act_q <= `RST_ACT;
            hys_q <= `RST_HYS;
        end
        else if (wr_en && wa_q == `OFS_MODE)
        begin
            // R3 digit per setpoint
            act_q <= hwdata[3:0];
            // R6 own hysteresis enable
            hys_q <= hwdata[7:4];
        end
        else if (menu_q == MENU_ACT && !locked && (pin_press[1] || pin_press[2]))
        begin
            // R3 leftmost is setpoint one
            act_q[3 - step_q[1:0]] <= ~act_q[3 - step_q[1:0]];
        end
    end

    // Colour settings: index 0 is the base colour, 1 to 4 above each setpoint.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 5; i++)
            begin
                col_q[i] <= colour_e'(`RST_COLOUR >> (2 * i));
            end
        end
        else if (wr_en && wa_q == `OFS_COLOUR)
        begin
            // R12 only three colours
            for (int i = 0; i < 5; i++)
            begin
                col_q[i] <= pick_colour(hwdata[2*i +: 2], col_q[i]);
            end
        end
        else if (menu_q == MENU_COL && !locked && (pin_press[1] || pin_press[2]))
        begin
            col_q[step_q] <= step_colour(col_q[step_q], pin_press[1]);
        end
    end

    // Menu: a program press while down is held opens the activation digits.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            menu_q <= MENU_IDLE;
            step_q <= 3'd0;
        end
        else if (pin_press[0])
        begin
            unique case (menu_q)
                MENU_IDLE:
                begin
                    if (pin_level[2])
                    begin
                        menu_q <= MENU_ACT;
                        step_q <= 3'd0;
                    end
                end
                MENU_ACT:
                begin
                    // R7 exit or colour menu
                    if (step_q == 3'd3)
                    begin
                        menu_q <= ctrl_q[`CTRL_TRI] ? MENU_COL : MENU_IDLE;
                        step_q <= 3'd0;
                    end
                    else
                    begin
                        // R4 advance one digit
                        step_q <= step_q + 3'd1;
                    end
                end
                MENU_COL:
                begin
                    // R13 base then four, exit
                    if (step_q == 3'd4)
                    begin
                        menu_q <= MENU_IDLE;
                        step_q <= 3'd0;
                    end
                    else
                    begin
                        step_q <= step_q + 3'd1;
                    end
                end
                default:
                begin
                    menu_q <= MENU_IDLE;
                    step_q <= 3'd0;
                end
            endcase
        end
    end

    // Blink phase of the digit under edit.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            blink_cnt_q <= 32'd0;
            blank_q <= 1'b0;
        end
        else if (blink_cnt_q >= 32'(BLINK_CYCLES - 1))
        begin
            blink_cnt_q <= 32'd0;
            blank_q <= ~blank_q;
        end
        else
        begin
            blink_cnt_q <= blink_cnt_q + 32'd1;
        end
    end

    // R4 flash digit, light point
    assign edit.state = menu_q;
    assign edit.step = step_q;
    assign edit.dp = (menu_q == MENU_ACT) ? (4'b1000 >> step_q[1:0]) : 4'b0000;
    assign edit.blank = (menu_q == MENU_ACT) && blank_q;

    // R18 pump band only when setpoint two is above one
    assign pump_act = ctrl_q[`CTRL_PUMP] && (sp_q[1] > sp_q[0]);

    // Alarm conditions with hysteresis, latched on each new result.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            alarm_q <= 4'h0;
        end
        // R20 evaluate each result
        else if (reading.valid)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (i == 0 && pump_act)
                begin
                    // R18 band between one and two
                    if (act_q[3])
                        alarm_q[0] <= alarm_q[0] ? (reading.value > sp_q[0])
                            : (reading.value > sp_q[1]);
                    else
                        alarm_q[0] <= alarm_q[0] ? (reading.value < sp_q[1])
                            : (reading.value < sp_q[0]);
                end
                else if (act_q[3 - i])
                begin
                    // R1 high above setpoint
                    if (alarm_q[i] && hys_q[i])
                        alarm_q[i] <= wide(reading.value)
                            >= wide(sp_q[i]) - $signed({2'b00, band_q});
                    else
                        alarm_q[i] <= reading.value > sp_q[i];
                end
                else
                begin
                    // R2 low below setpoint
                    if (alarm_q[i] && hys_q[i])
                        alarm_q[i] <= wide(reading.value)
                            <= wide(sp_q[i]) + $signed({2'b00, band_q});
                    else
                        alarm_q[i] <= reading.value < sp_q[i];
                end
            end
        end
    end

    // Second tick for the setpoint one delays.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sec_cnt_q <= 32'd0;
        end
        else if (sec_tick || alarm_q[0] == relay_one_q)
        begin
            sec_cnt_q <= 32'd0;
        end
        else
        begin
            sec_cnt_q <= sec_cnt_q + 32'd1;
        end
    end
    assign sec_tick = sec_cnt_q >= 32'(CYCLES_PER_SECOND - 1);

    // R5 delays on setpoint one only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            relay_one_q <= 1'b0;
            dly_cnt_q <= 14'd0;
        end
        else if (alarm_q[0] == relay_one_q)
        begin
            dly_cnt_q <= 14'd0;
        end
        // R19 continuous make delay
        else if (dly_cnt_q >= (alarm_q[0] ? make_q : break_q))
        begin
            relay_one_q <= alarm_q[0];
            dly_cnt_q <= 14'd0;
        end
        else if (sec_tick)
        begin
            dly_cnt_q <= dly_cnt_q + 14'd1;
        end
    end

    // R15 order three, one, four, two
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            relay_drive <= 4'h0;
        end
        else
        begin
            relay_drive <= {alarm_q[1], alarm_q[3], relay_one_q, alarm_q[2]};
        end
    end

    // Zone colour: the highest setpoint value the reading exceeds picks it.
    always_comb
    begin
        colour_e pick;
        logic signed [15:0] best;
        logic found;
        pick = col_q[0];
        best = 16'sh0000;
        found = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            // R10 by value not number
            // R11 tie goes to higher number
            if (reading.value > sp_q[i] && (!found || sp_q[i] >= best))
            begin
                pick = col_q[i + 1];
                best = sp_q[i];
                found = 1'b1;
            end
        end
        zone_colour = pick;
    end

    // Latched per result, so a setpoint edit alone never recolours the bar.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            colour_q <= COLOUR_GREEN;
        end
        // R20 new result recolours
        else if (reading.valid)
        begin
            // R9 base below lowest
            colour_q <= zone_colour;
        end
    end

    // R8 one colour whole bar
    assign bar.colour = colour_q;
    // R17 dim halves brightness
    assign bar.brightness = dimmed ? {1'b0, ctrl_q[`CTRL_BRT_HI]}
        : ctrl_q[`CTRL_BRT_HI:`CTRL_BRT_LO];
    // R14 left means below
    assign bar.horizontal = ctrl_q[`CTRL_HORIZ];
endmodule

// file: include/meter_map.svh
`ifndef METER_MAP_SVH
`define METER_MAP_SVH

// Register byte offsets on the AHB-Lite port.
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_HBAND 8'h08
`define OFS_SP1 8'h0c
`define OFS_SP2 8'h10
`define OFS_SP3 8'h14
`define OFS_SP4 8'h18
`define OFS_MAKE 8'h1c
`define OFS_BREAK 8'h20
`define OFS_COLOUR 8'h24
`define OFS_STATUS 8'h28

// Control register field positions.
`define CTRL_TRI 0
`define CTRL_HORIZ 1
`define CTRL_PUMP 2
`define CTRL_BRT_LO 4
`define CTRL_BRT_HI 5

// Mode register: activation digits in [3:0], hysteresis enables in [7:4].
`define MODE_ACT_LO 0
`define MODE_HYS_LO 4

// Status register field positions.
`define ST_RELAY_LO 0
`define ST_ALARM_LO 4
`define ST_COLOUR_LO 8
`define ST_MENU_LO 12
`define ST_LOCK 16
`define ST_DIM 17

// Reset values.
`define RST_CTRL 6'h30
`define RST_ACT 4'hf
`define RST_HYS 4'h0
`define RST_HBAND 16'h000a
`define RST_SP 16'h0000
`define RST_DELAY 14'h0000
`define RST_COLOUR 10'h000

// Timing: delays count in seconds, edit digit blinks with this half period.
`define CLK_HZ 25000000
`define DELAY_UNIT_S 1
`define BLINK_MS 250
`define DELAY_MAX 14'd9999

`endif

// file: include/meter_pkg.sv
package meter_pkg;

    typedef enum logic [1:0]
    {
        COLOUR_GREEN = 2'b00,
        COLOUR_ORANGE = 2'b01,
        COLOUR_RED = 2'b10
    } colour_e;

    typedef enum logic [2:0]
    {
        MENU_IDLE = 3'b001,
        MENU_ACT = 3'b010,
        MENU_COL = 3'b100
    } menu_e;

    typedef struct packed
    {
        logic valid;
        logic signed [15:0] value;
    } reading_s;

    typedef struct packed
    {
        colour_e colour;
        logic [1:0] brightness;
        logic horizontal;
    } bar_s;

    typedef struct packed
    {
        menu_e state;
        logic [2:0] step;
        logic [3:0] dp;
        logic blank;
    } edit_s;

endpackage

// file: testbench/meter_properties.sv
`timescale 1ns/1ps
// Watches the relay, bargraph and menu outputs against the reading stream and pins.
module meter_properties
    import meter_pkg::*;
(
    input wire logic hclk, // System clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire meter_pkg::reading_s reading, // Conversion result stream.
    input wire logic dim_n, // Dim pin, low when tied to common.
    input wire logic [3:0] relay_drive, // Relay coils.
    input wire meter_pkg::bar_s bar, // Bargraph colour and brightness.
    input wire meter_pkg::edit_s edit // Menu state.
);
    import meter_pkg::*;

    // All checks share the one clock and its reset.
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    colour_code_a: assert property (bar.colour != 2'b11)
        else $error("bar colour holds an unused code");

    // Colour may only move one cycle after a new conversion result.
    colour_on_reading_a: assert property ($changed(bar.colour) |-> $past(reading.valid))
        else $error("bar colour changed without a new reading");

    // Undelayed relays follow a reading by exactly two edges.
    relay_on_reading_a: assert property (
        $changed(relay_drive[0]) || $changed(relay_drive[3:2]) |-> $past(reading.valid, 2))
        else $error("undelayed relay moved off the reading pipeline");

    // Three settled low samples of the dim pin must clear the upper brightness bit.
    dim_half_a: assert property ((!dim_n)[*3] |-> !bar.brightness[1])
        else $error("dim did not halve the brightness");

    edit_point_a: assert property (
        edit.state == MENU_ACT |-> edit.dp == (4'b1000 >> edit.step))
        else $error("decimal point does not mark the edited digit");

    point_idle_a: assert property (
        edit.state != MENU_ACT |-> edit.dp == 4'h0 && !edit.blank)
        else $error("point or blink shown outside digit editing");

    colour_entry_a: assert property (
        $past(edit.state) == MENU_ACT && edit.state == MENU_COL
        |-> $past(edit.step) == 3'd3 && edit.step == 3'd0)
        else $error("colour menu entered from a wrong digit");

    colour_exit_a: assert property (
        $past(edit.state) == MENU_COL && edit.state == MENU_IDLE |-> $past(edit.step) == 3'd4)
        else $error("colour menu left before the last step");
endmodule

bind setpoint_relay_color_logic meter_properties i_meter_properties (
    .hclk(hclk),
    .hresetn(hresetn),
    .reading(reading),
    .dim_n(dim_n),
    .relay_drive(relay_drive),
    .bar(bar),
    .edit(edit)
);

// file: testbench/testbench.sv
`timescale 1ns/1ps
`include "meter_map.svh"
module testbench;
    import meter_pkg::*;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    reading_s reading;
    logic [2:0] btn_n;
    logic lock_n;
    logic dim_n;
    logic [3:0] relay_drive;
    bar_s bar;
    edit_s edit;
    logic [31:0] rd;
    int miscompares;
    int tests_run;

    // Short second and blink counts keep the delay scenarios brief.
    setpoint_relay_color_logic #(.CYCLES_PER_SECOND(10), .BLINK_CYCLES(4))
        i_setpoint_relay_color_logic (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reading(reading),
        .btn_prog_n(btn_n[2]), .btn_up_n(btn_n[1]), .btn_down_n(btn_n[0]),
        .lock_n(lock_n), .dim_n(dim_n), .relay_drive(relay_drive), .bar(bar), .edit(edit));

    // Free-running 25 MHz clock.
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // The single slave's ready is the bus ready, so every wait loops on it.
    task automatic ahb_access(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        ahb_access(a, 1'b1, d);
    endtask

    task automatic ahb_read(input logic [7:0] a);
        ahb_access(a, 1'b0, 32'h00000000);
    endtask

    // One-cycle result pulse, then room for the relay pipeline to settle.
    task automatic send_reading(input logic signed [15:0] v);
        reading <= '{valid: 1'b1, value: v};
        @(posedge hclk);
        reading.valid <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    task automatic run_case(input logic [31:0] mode, input logic signed [15:0] v,
        input logic [3:0] relays, input logic [1:0] colour);
        ahb_write(`OFS_MODE, mode);
        send_reading(v);
        check(relay_drive, relays);
        check(bar.colour, colour);
    endtask

    // Pins are held long enough to pass the two-flop synchroniser.
    task automatic press(input logic [2:0] mask);
        btn_n <= btn_n & ~mask;
        wait_cycles(4);
        btn_n <= 3'b111;
        wait_cycles(4);
    endtask

    task automatic enter_menu;
        btn_n <= 3'b110;
        wait_cycles(4);
        press(3'b100);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run in the usual place.
    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        complete_run;
    end

    // Main sequence: setpoints 100, 200, 50, 300; zone colours green, orange, red, orange, green.
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        reading = '0;
        btn_n = 3'b111;
        lock_n = 1'b1;
        dim_n = 1'b1;
        miscompares = 0;
        tests_run = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb_read(`OFS_MODE);
        check(rd, 32'h0000000f);
        ahb_read(8'h40);
        check(rd, 32'h00000000);
        ahb_write(`OFS_SP1, 32'h00000064);
        ahb_write(`OFS_SP2, 32'h000000c8);
        ahb_write(`OFS_SP3, 32'h00000032);
        ahb_write(`OFS_SP4, 32'h0000012c);
        ahb_write(`OFS_COLOUR, 32'h00000064);
        run_case(32'hf, 16'sd250, 4'hb, 2'b10);
        run_case(32'hf, 16'sd100, 4'h1, 2'b01);
        run_case(32'hf, 16'sd0, 4'h0, 2'b00);
        run_case(32'hf, 16'sd350, 4'hf, 2'b00);
        run_case(32'h2, 16'sd150, 4'hd, 2'b01);
        run_case(32'h0, 16'sd75, 4'he, 2'b01);
        ahb_write(`OFS_SP4, 32'h000000c8);
        run_case(32'hf, 16'sd250, 4'hf, 2'b00);
        run_case(32'h4f, 16'sd45, 4'h1, 2'b00);
        // Make delay of two seconds, broken once by a clear reading.
        send_reading(16'sd0);
        ahb_write(`OFS_MAKE, 32'h00000002);
        send_reading(16'sd150);
        wait_cycles(8);
        send_reading(16'sd0);
        send_reading(16'sd150);
        wait_cycles(10);
        check(relay_drive, 4'h1);
        check(relay_drive[1], 1'b0);
        wait_cycles(20);
        check(relay_drive[1], 1'b1);
        ahb_write(`OFS_MAKE, 32'h00000000);
        send_reading(16'sd0);
        // Pump band between setpoints one and two.
        ahb_write(`OFS_CTRL, 32'h00000034);
        send_reading(16'sd150);
        check(relay_drive[1], 1'b0);
        send_reading(16'sd250);
        check(relay_drive[1], 1'b1);
        send_reading(16'sd150);
        check(relay_drive[1], 1'b1);
        send_reading(16'sd50);
        check(relay_drive[1], 1'b0);
        ahb_write(`OFS_CTRL, 32'h00000032);
        wait_cycles(1);
        check(bar.horizontal, 1'b1);
        dim_n <= 1'b0;
        wait_cycles(4);
        check(bar.brightness, 2'b01);
        dim_n <= 1'b1;
        lock_n <= 1'b0;
        wait_cycles(4);
        ahb_write(`OFS_CTRL, 32'h00000000);
        ahb_read(`OFS_CTRL);
        check(rd, 32'h00000032);
        lock_n <= 1'b1;
        wait_cycles(4);
        // Digit editing with a single-colour bar, then with the tricolour one.
        ahb_write(`OFS_MODE, 32'h0000000f);
        enter_menu;
        check(edit.state, MENU_ACT);
        check(edit.dp, 4'h8);
        rd = {31'h0, edit.blank};
        wait_cycles(4);
        check(edit.blank, !rd[0]);
        press(3'b010);
        for (int i = 1; i < 4; i++)
        begin
            press(3'b100);
            check(edit.dp, 4'h8 >> i);
        end
        press(3'b100);
        check(edit.state, MENU_IDLE);
        ahb_read(`OFS_MODE);
        check(rd, 32'h00000007);
        ahb_write(`OFS_CTRL, 32'h00000031);
        enter_menu;
        repeat (4) press(3'b100);
        check(edit.state, MENU_COL);
        press(3'b010);
        repeat (4) press(3'b100);
        check(edit.step, 3'd4);
        press(3'b100);
        check(edit.state, MENU_IDLE);
        ahb_read(`OFS_COLOUR);
        check(rd, 32'h00000065);
        complete_run;
    end
endmodule
